/* design/msl_pkg.sv */
// Shared constants, types and helpers of the monitor serial link
package msl_pkg;

    // Vector pages and low bytes
    localparam logic [7:0] MSL_USER_PAGE = 8'hff;
    localparam logic [7:0] MSL_MON_PAGE = 8'hfe;
    localparam logic [7:0] MSL_VEC_RST_LO = 8'hfe;
    localparam logic [7:0] MSL_VEC_BRK_LO = 8'hfc;

    // Interrupt-request pin level codes
    localparam logic [1:0] MSL_IRQ_NORMAL = 2'h0;
    localparam logic [1:0] MSL_IRQ_TEST = 2'h1;
    localparam logic [1:0] MSL_IRQ_SUPPLY = 2'h2;
    localparam logic [1:0] MSL_IRQ_GROUND = 2'h3;

    // Baud divide ratios in core clocks per bit
    localparam logic [10:0] MSL_DIV_LO = 11'h200;
    localparam logic [10:0] MSL_DIV_HI = 11'h400;
    localparam logic [10:0] MSL_DIV_PLL = 11'h100;

    // Clock step-up from crystal to internal bus
    localparam int unsigned MSL_XTAL_HZ = 32768;
    localparam int unsigned MSL_PLL_HZ = 2457600;
    localparam logic [7:0] MSL_PLL_MULT = 8'(MSL_PLL_HZ / MSL_XTAL_HZ);

    // Bit-time counts
    localparam logic [3:0] MSL_GAP_BITS = 4'h2;
    localparam logic [3:0] MSL_BRK_HIGH_BITS = 4'h2;
    localparam logic [3:0] MSL_CANCEL_BITS = 4'hb;
    localparam logic [3:0] MSL_FRAME_BITS = 4'ha;
    localparam logic [9:0] MSL_BRK_FRAME = 10'h000;
    localparam logic [9:0] MSL_IDLE_FRAME = 10'h3ff;

    // Command codes
    localparam logic [7:0] MSL_CMD_READ = 8'h01;
    localparam logic [7:0] MSL_CMD_WRITE = 8'h02;
    localparam logic [7:0] MSL_CMD_INDEXED_READ_CMD = 8'h03;
    localparam logic [7:0] MSL_CMD_INDEXED_WRITE_CMD = 8'h04;
    localparam logic [7:0] MSL_CMD_SPREAD = 8'h05;
    localparam logic [7:0] MSL_CMD_RUN = 8'h06;

    typedef enum logic [1:0] {MSL_RATIO_512, MSL_RATIO_1024, MSL_RATIO_PLL} msl_ratio_e;

    // Core clocks per bit for a ratio
    function automatic logic [10:0] msl_ratio_div(input msl_ratio_e r);
        if (r == MSL_RATIO_1024) begin
            return MSL_DIV_HI;
        end else if (r == MSL_RATIO_PLL) begin
            return MSL_DIV_PLL;
        end
        return MSL_DIV_LO;
    endfunction : msl_ratio_div

    // Operand bytes following a command byte
    function automatic logic [1:0] msl_operands(input logic [7:0] c);
        if (c == MSL_CMD_READ) begin
            return 2'h2;
        end else if (c == MSL_CMD_WRITE) begin
            return 2'h3;
        end else if (c == MSL_CMD_INDEXED_WRITE_CMD) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction : msl_operands

    // Known command code
    function automatic logic msl_is_cmd(input logic [7:0] c);
        return (c >= MSL_CMD_READ) && (c <= MSL_CMD_RUN);
    endfunction : msl_is_cmd

endpackage : msl_pkg

/* design/msl_baud.sv */
// Bit-rate enable generator with restart
`timescale 1ns/1ps
module msl_baud import msl_pkg::*; (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_restart,
    input wire msl_ratio_e i_ratio,
    // Bit enable and period
    output logic o_tick,
    output logic [10:0] o_div
);

    logic [10:0] cnt_r;

    // Period from the ratio latched at entry
    assign o_div = msl_ratio_div(i_ratio);
    assign o_tick = (cnt_r == o_div - 11'h1) && !i_restart;

    // Free-running bit counter, restarted at bit-aligned events
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || i_restart) begin
            cnt_r <= 11'h000;
        end else if (cnt_r == o_div - 11'h1) begin
            cnt_r <= 11'h000;
        end else begin
            cnt_r <= cnt_r + 11'h001;
        end
    end

endmodule : msl_baud

/* design/msl_rx.sv */
// Monitor line receiver with break detection
`timescale 1ns/1ps
module msl_rx import msl_pkg::*; (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_en,
    input wire logic [10:0] i_div,
    // Line
    input wire logic i_pin,
    // Results
    output logic o_byte_vld,
    output logic [7:0] o_byte,
    output logic o_break
);

    typedef enum logic [1:0] {MSL_RX_IDLE, MSL_RX_START, MSL_RX_BITS, MSL_RX_WAITHI} msl_rx_e;

    logic s1_r, s2_r, s3_r, line_r;
    msl_rx_e st_r;
    logic [10:0] cnt_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;

    // Three-stage synchroniser, change taken once stages two and three agree
    always_ff @(posedge i_core_clk) begin
        s1_r <= i_pin;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (!i_nrst) begin
            line_r <= 1'b1;
        end else if (s2_r == s3_r) begin
            line_r <= s3_r;
        end
    end

    // Frame sampler, mid-bit sampling
    always_ff @(posedge i_core_clk) begin
        o_byte_vld <= 1'b0;
        o_break <= 1'b0;
        if (!i_nrst || !i_en) begin
            st_r <= MSL_RX_IDLE;
            cnt_r <= 11'h000;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            o_byte <= 8'h00;
        end else begin
            case (st_r)
                MSL_RX_IDLE: begin
                    cnt_r <= 11'h000;
                    if (!line_r) begin
                        st_r <= MSL_RX_START;
                    end
                end
                MSL_RX_START: begin
                    if (cnt_r == (i_div >> 1) - 11'h1) begin
                        cnt_r <= 11'h000;
                        bit_r <= 4'h0;
                        st_r <= line_r ? MSL_RX_IDLE : MSL_RX_BITS;
                    end else begin
                        cnt_r <= cnt_r + 11'h001;
                    end
                end
                MSL_RX_BITS: begin
                    if (cnt_r == i_div - 11'h1) begin
                        cnt_r <= 11'h000;
                        bit_r <= bit_r + 4'h1;
                        if (bit_r != 4'h8) begin
                            sh_r <= {line_r, sh_r[7:1]};
                        end else begin
                            st_r <= MSL_RX_WAITHI;
                            if (line_r) begin
                                o_byte_vld <= 1'b1;
                                o_byte <= sh_r;
                            end else if (sh_r == 8'h00) begin
                                o_break <= 1'b1;
                            end
                        end
                    end else begin
                        cnt_r <= cnt_r + 11'h001;
                    end
                end
                default: begin
                    if (line_r) begin
                        st_r <= MSL_RX_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    property p_break_zero;
        o_break |-> $past(sh_r) == 8'h00 && $past(st_r) == MSL_RX_BITS && !$past(line_r);
    endproperty
    a_break_zero: assert property (p_break_zero) else $error("break without ten zero bits");

endmodule : msl_rx

/* design/msl_top.sv */
// Monitor-mode serial link: entry, vectors, baud, echo and command execution
`timescale 1ns/1ps
// Behaviour
// - Monitor mode uses FE-page reset/break vectors
// - Blank-vector entry exits only on power-on
// - NRZ bytes, equal transmit and receive rates
// - Start plus nine zero bits is break
// - Break answered by two high bits, echo
// - Test voltage: divide 1024 high, 512 low
// - Supply-level entry fixes divide at 1024
// - Ground entry steps crystal up to bus
// - Supply/ground entry needs blank reset vector
// - Six commands: read, write, indexed, SP, run
// - Every byte received while idle is echoed back
// - Eleven-bit wait lets break cancel command
// - Two-bit gap before echo and read data
// - Read data follows echo of final byte
// - Entry only after power-on with conditions
module msl_top import msl_pkg::*; (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_por,
    // Entry straps
    input wire logic [1:0] i_irq_level,
    input wire logic i_baud_divider_select_pin,
    input wire logic i_reset_vector_blank,
    // Monitor data pin
    input wire logic i_monitor_data_pin,
    output logic o_monitor_data_pin,
    output logic o_monitor_data_pin_oe_n,
    // Memory port
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    // Processor
    input wire logic [15:0] i_stack_ptr,
    output logic o_run,
    // Mode status
    output logic o_monitor_mode,
    output logic o_blank_entry,
    output logic o_pll_en,
    output logic [7:0] o_pll_mult,
    output logic [15:0] o_reset_vector_addr,
    output logic [15:0] o_break_swi_vector_addr
);

    typedef enum logic [2:0] {
        MSL_ST_IDLE, MSL_ST_GAP, MSL_ST_TX, MSL_ST_HOLD,
        MSL_ST_RESP, MSL_ST_MEMA, MSL_ST_MEMB, MSL_ST_BRKHI
    } msl_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture and mode entry

    logic [2:0] strap_s1_r, strap_s2_r, strap_s3_r, strap_r;
    logic nrst_d_r, por_pend_r, release_w;
    msl_ratio_e ratio_r;
    logic [1:0] irq_w;
    logic sel_w;

    assign irq_w = strap_r[2:1];
    assign sel_w = strap_r[0];
    assign release_w = i_nrst && !nrst_d_r;

    // Pin straps through three stages
    always_ff @(posedge i_core_clk) begin
        strap_s1_r <= {i_irq_level, i_baud_divider_select_pin};
        strap_s2_r <= strap_s1_r;
        strap_s3_r <= strap_s2_r;
        if (strap_s2_r == strap_s3_r) begin
            strap_r <= strap_s3_r;
        end
        nrst_d_r <= i_nrst;
    end

    // Mode state survives pin reset except monitor mode without blank-vector entry, which pin reset clears; power-on clears all but the ratio, set to 1024
    always_ff @(posedge i_core_clk) begin
        if (i_por) begin
            por_pend_r <= 1'b1;
            o_monitor_mode <= 1'b0;
            o_blank_entry <= 1'b0;
            o_pll_en <= 1'b0;
            o_pll_mult <= 8'h00;
            ratio_r <= MSL_RATIO_1024;
        end else if (release_w) begin
            por_pend_r <= 1'b0;
            if (por_pend_r) begin
                if (irq_w == MSL_IRQ_TEST) begin
                    o_monitor_mode <= 1'b1;
                    ratio_r <= sel_w ? MSL_RATIO_1024 : MSL_RATIO_512;
                end else if (irq_w == MSL_IRQ_SUPPLY && i_reset_vector_blank) begin
                    o_monitor_mode <= 1'b1;
                    o_blank_entry <= 1'b1;
                    ratio_r <= MSL_RATIO_1024;
                end else if (irq_w == MSL_IRQ_GROUND && i_reset_vector_blank) begin
                    o_monitor_mode <= 1'b1;
                    o_blank_entry <= 1'b1;
                    o_pll_en <= 1'b1;
                    o_pll_mult <= MSL_PLL_MULT;
                    ratio_r <= MSL_RATIO_PLL;
                end
            end else if (!o_blank_entry) begin
                o_monitor_mode <= 1'b0;
            end
        end
    end

    // Vector addresses follow the mode
    always_ff @(posedge i_core_clk) begin
        o_reset_vector_addr <= {o_monitor_mode ? MSL_MON_PAGE : MSL_USER_PAGE, MSL_VEC_RST_LO};
        o_break_swi_vector_addr <= {o_monitor_mode ? MSL_MON_PAGE : MSL_USER_PAGE, MSL_VEC_BRK_LO};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit timing and receiver

    logic tick_w, restart_r, rx_vld_w, rx_brk_w, rx_en_w;
    logic [10:0] div_w;
    logic [7:0] rx_byte_w;

    // Receive only while the line is released
    assign rx_en_w = o_monitor_mode && o_monitor_data_pin_oe_n;

    msl_baud u_baud (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_restart(restart_r),
        .i_ratio(ratio_r),
        .o_tick(tick_w),
        .o_div(div_w)
    );

    msl_rx u_rx (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_en(rx_en_w),
        .i_div(div_w),
        .i_pin(i_monitor_data_pin),
        .o_byte_vld(rx_vld_w),
        .o_byte(rx_byte_w),
        .o_break(rx_brk_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command interpreter

    msl_state_e st_r;
    logic [3:0] cnt_r;
    logic [9:0] frame_r;
    logic [7:0] cmd_r;
    logic cmd_ok_r, resp_mode_r;
    logic [1:0] need_r, resp_r;
    logic [23:0] opnd_r;
    logic [15:0] idx_r;

    assign o_monitor_data_pin = frame_r[0];

    // Sequencer, shifter and memory strobes
    always_ff @(posedge i_core_clk) begin
        o_mem_rd <= 1'b0;
        o_mem_wr <= 1'b0;
        o_run <= 1'b0;
        restart_r <= 1'b0;
        if (!i_nrst || !o_monitor_mode) begin
            st_r <= MSL_ST_IDLE;
            cnt_r <= 4'h0;
            frame_r <= MSL_IDLE_FRAME;
            o_monitor_data_pin_oe_n <= 1'b1;
            cmd_r <= 8'h00;
            cmd_ok_r <= 1'b0;
            resp_mode_r <= 1'b0;
            need_r <= 2'h0;
            resp_r <= 2'h0;
            opnd_r <= 24'h000000;
            idx_r <= 16'h0000;
            o_mem_addr <= 16'h0000;
            o_mem_wdata <= 8'h00;
        end else if (rx_brk_w) begin
            st_r <= MSL_ST_BRKHI;
            cnt_r <= 4'h0;
            restart_r <= 1'b1;
            frame_r <= MSL_IDLE_FRAME;
            o_monitor_data_pin_oe_n <= 1'b0;
            cmd_ok_r <= 1'b0;
            resp_mode_r <= 1'b0;
            need_r <= 2'h0;
            resp_r <= 2'h0;
        end else begin
            case (st_r)
                MSL_ST_IDLE: begin
                    if (rx_vld_w) begin
                        frame_r <= {1'b1, rx_byte_w, 1'b0};
                        st_r <= MSL_ST_GAP;
                        cnt_r <= 4'h0;
                        restart_r <= 1'b1;
                        if (need_r == 2'h0) begin
                            cmd_r <= rx_byte_w;
                            cmd_ok_r <= msl_is_cmd(rx_byte_w);
                            need_r <= msl_operands(rx_byte_w);
                        end else begin
                            need_r <= need_r - 2'h1;
                            opnd_r <= {opnd_r[15:0], rx_byte_w};
                        end
                    end
                end
                MSL_ST_GAP: begin
                    if (tick_w) begin
                        if (cnt_r == MSL_GAP_BITS - 4'h1) begin
                            st_r <= MSL_ST_TX;
                            cnt_r <= 4'h0;
                            o_monitor_data_pin_oe_n <= 1'b0;
                        end else begin
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                MSL_ST_TX: begin
                    if (tick_w) begin
                        frame_r <= {1'b1, frame_r[9:1]};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == MSL_FRAME_BITS - 4'h1) begin
                            cnt_r <= 4'h0;
                            frame_r <= MSL_IDLE_FRAME;
                            o_monitor_data_pin_oe_n <= 1'b1;
                            if (resp_mode_r) begin
                                st_r <= MSL_ST_RESP;
                            end else if (need_r != 2'h0 || !cmd_ok_r) begin
                                st_r <= MSL_ST_IDLE;
                            end else begin
                                st_r <= MSL_ST_HOLD;
                                restart_r <= 1'b1;
                            end
                        end
                    end
                end
                MSL_ST_HOLD: begin
                    if (tick_w) begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == MSL_CANCEL_BITS - 4'h1) begin
                            cnt_r <= 4'h0;
                            cmd_ok_r <= 1'b0;
                            st_r <= MSL_ST_IDLE;
                            if (cmd_r == MSL_CMD_WRITE) begin
                                o_mem_wr <= 1'b1;
                                o_mem_addr <= opnd_r[23:8];
                                o_mem_wdata <= opnd_r[7:0];
                                idx_r <= opnd_r[23:8] + 16'h0001;
                            end else if (cmd_r == MSL_CMD_INDEXED_WRITE_CMD) begin
                                o_mem_wr <= 1'b1;
                                o_mem_addr <= idx_r;
                                o_mem_wdata <= opnd_r[7:0];
                                idx_r <= idx_r + 16'h0001;
                            end else if (cmd_r == MSL_CMD_RUN) begin
                                o_run <= 1'b1;
                            end else begin
                                st_r <= MSL_ST_RESP;
                                resp_mode_r <= 1'b1;
                                resp_r <= (cmd_r == MSL_CMD_READ) ? 2'h1 : 2'h2;
                                if (cmd_r == MSL_CMD_READ) begin
                                    idx_r <= opnd_r[15:0];
                                end
                            end
                        end
                    end
                end
                MSL_ST_RESP: begin
                    if (resp_r == 2'h0) begin
                        resp_mode_r <= 1'b0;
                        st_r <= MSL_ST_IDLE;
                    end else begin
                        resp_r <= resp_r - 2'h1;
                        if (cmd_r == MSL_CMD_SPREAD) begin
                            frame_r <= {1'b1, (resp_r == 2'h2) ? i_stack_ptr[15:8] : i_stack_ptr[7:0], 1'b0};
                            st_r <= MSL_ST_GAP;
                            restart_r <= 1'b1;
                        end else begin
                            o_mem_rd <= 1'b1;
                            o_mem_addr <= idx_r;
                            idx_r <= idx_r + 16'h0001;
                            st_r <= MSL_ST_MEMA;
                        end
                    end
                end
                MSL_ST_MEMA: begin
                    st_r <= MSL_ST_MEMB;
                end
                MSL_ST_MEMB: begin
                    frame_r <= {1'b1, i_mem_rdata, 1'b0};
                    st_r <= MSL_ST_GAP;
                    restart_r <= 1'b1;
                end
                default: begin
                    if (tick_w) begin
                        if (cnt_r == MSL_BRK_HIGH_BITS - 4'h1) begin
                            st_r <= MSL_ST_TX;
                            cnt_r <= 4'h0;
                            frame_r <= MSL_BRK_FRAME;
                        end else begin
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    property p_vec_page;
        o_monitor_mode && $stable(o_monitor_mode) |=> o_reset_vector_addr == {MSL_MON_PAGE, MSL_VEC_RST_LO};
    endproperty
    a_vec_page: assert property (p_vec_page) else $error("monitor reset vector not on FE page");

    property p_blank_stay;
        release_w && !por_pend_r && !i_por && o_blank_entry |=> o_monitor_mode;
    endproperty
    a_blank_stay: assert property (p_blank_stay) else $error("pin reset left blank-vector monitor");

    property p_brk_high;
        st_r == MSL_ST_BRKHI |-> o_monitor_data_pin && !o_monitor_data_pin_oe_n;
    endproperty
    a_brk_high: assert property (p_brk_high) else $error("line not driven high after break");

    property p_div_test;
        release_w && !i_por && por_pend_r && irq_w == MSL_IRQ_TEST |=> div_w == (sel_w ? MSL_DIV_HI : MSL_DIV_LO);
    endproperty
    a_div_test: assert property (p_div_test) else $error("wrong test-voltage divide");

    property p_div_supply;
        release_w && !i_por && por_pend_r && irq_w == MSL_IRQ_SUPPLY && i_reset_vector_blank
            |=> div_w == MSL_DIV_HI;
    endproperty
    a_div_supply: assert property (p_div_supply) else $error("supply entry not divide 1024");

    property p_pll;
        $rose(o_pll_en) |-> o_pll_mult == MSL_PLL_MULT && $past(irq_w) == MSL_IRQ_GROUND;
    endproperty
    a_pll: assert property (p_pll) else $error("PLL step-up without ground entry");

    property p_blank_need;
        $rose(o_blank_entry) |-> $past(i_reset_vector_blank);
    endproperty
    a_blank_need: assert property (p_blank_need) else $error("blank entry with programmed vector");

    property p_echo;
        st_r == MSL_ST_IDLE && rx_vld_w && !rx_brk_w && o_monitor_mode |=> frame_r[8:1] == $past(rx_byte_w);
    endproperty
    a_echo: assert property (p_echo) else $error("echo frame differs from received byte");

    property p_gap;
        $rose(st_r == MSL_ST_TX) |-> $past(st_r) == MSL_ST_GAP || $past(st_r) == MSL_ST_BRKHI;
    endproperty
    a_gap: assert property (p_gap) else $error("transmit without preceding gap");

endmodule : msl_top

/* verif/msl_host.sv */
// Host programmer model on the monitor line
`timescale 1ns/1ps
module msl_host (
    // Clock and line
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_drive
);
    localparam int BIT_N = 256;
    initial o_drive = 1'b1;
    // Frame out, bit zero first
    task automatic send(input logic [9:0] fr);
        for (int i = 0; i < 10; i++) begin
            o_drive = fr[i];
            repeat (BIT_N) @(posedge i_clk);
            #1;
        end
        o_drive = 1'b1;
    endtask : send
    // Frame in, mid-bit samples, then quiet bit
    task automatic recv(output logic [9:0] fr, output bit ok);
        ok = 1'b0;
        fr = '1;
        for (int t = 0; t < 6000 && !ok; t++) begin
            @(posedge i_clk);
            #1 ok = (i_line === 1'b0);
        end
        repeat (BIT_N / 2) @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            fr[i] = i_line;
            repeat (BIT_N) @(posedge i_clk);
        end
        repeat (BIT_N) @(posedge i_clk);
        #1;
    endtask : recv
endmodule : msl_host

/* verif/tb_top.sv */
// Self-checking bench for the monitor serial link
`timescale 1ns/1ps
module tb_top;
    import msl_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_por = 1'b1;
    logic [1:0] i_irq_level = MSL_IRQ_NORMAL;
    logic i_blank = 1'b0;
    logic [7:0] rdata = 8'h00;
    logic sel = 1'b0;
    logic [15:0] sp = 16'h0000;
    logic pin, oe_n, drv, o_mem_rd, o_mem_wr, o_run, o_monitor_mode, o_blank_entry, o_pll_en;
    logic [15:0] o_mem_addr, o_reset_vector_addr, o_break_swi_vector_addr;
    logic [7:0] o_mem_wdata, o_pll_mult;
    logic [9:0] fr;
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] mem [int];
    bit ok;
    int err_total = 0;
    int n_checks = 0;
    wire logic line = oe_n ? drv : pin;
    initial forever #50 i_core_clk = ~i_core_clk;
    msl_top dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_por(i_por), .i_irq_level(i_irq_level),
        .i_baud_divider_select_pin(sel), .i_reset_vector_blank(i_blank), .i_monitor_data_pin(line),
        .o_monitor_data_pin(pin), .o_monitor_data_pin_oe_n(oe_n), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(rdata), .i_stack_ptr(sp),
        .o_run(o_run), .o_monitor_mode(o_monitor_mode), .o_blank_entry(o_blank_entry), .o_pll_en(o_pll_en),
        .o_pll_mult(o_pll_mult), .o_reset_vector_addr(o_reset_vector_addr),
        .o_break_swi_vector_addr(o_break_swi_vector_addr));
    msl_host host (.i_clk(i_core_clk), .i_line(line), .o_drive(drv));
    // Memory model with one-cycle read answer
    always @(posedge i_core_clk) begin
        if (o_mem_wr === 1'b1) begin
            mem[o_mem_addr] = o_mem_wdata;
        end
        if (o_mem_rd === 1'b1) begin
            rdata <= #1 mem.exists(o_mem_addr) ? mem[o_mem_addr] : 8'h00;
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tmo(input bit good);
        if (!good) begin
            err_total++;
            $display("Error timeout expected 1 seen 0");
            give_verdict();
        end
    endtask : tmo
    task automatic rst(input logic [1:0] irq, input logic blank, input logic por);
        i_irq_level = irq;
        i_blank = blank;
        i_nrst = 1'b0;
        i_por = por;
        repeat (6) @(posedge i_core_clk);
        #1 i_por = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1 i_nrst = 1'b1;
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask : rst
    // One byte out, its echo checked
    task automatic xfer(input logic [7:0] b);
        host.send({1'b1, b, 1'b0});
        host.recv(fr, ok);
        tmo(ok);
        chk("echo", {6'h00, 1'b1, b, 1'b0}, {6'h00, fr});
    endtask : xfer
    task automatic wait_hi(ref logic s);
        ok = 1'b0;
        for (int t = 0; t < 4000 && !ok; t++) begin
            @(posedge i_core_clk);
            #1 ok = (s === 1'b1);
        end
        tmo(ok);
    endtask : wait_hi
    // Main sequence
    initial begin
        void'($urandom(25590));
        a = 16'($urandom);
        d = 8'($urandom);
        sel = 1'($urandom);
        sp = 16'($urandom);
        rst(MSL_IRQ_SUPPLY, 1'b0, 1'b1);
        chk("mode", 16'h0000, {15'h0, o_monitor_mode});
        chk("rst_vec", 16'hfffe, o_reset_vector_addr);
        rst(MSL_IRQ_TEST, 1'b0, 1'b1);
        chk("mode", 16'h0002, {14'h0, o_monitor_mode, o_blank_entry});
        chk("pll", 16'h0000, {7'h0, o_pll_en, o_pll_mult});
        rst(MSL_IRQ_TEST, 1'b0, 1'b0);
        chk("mode", 16'h0000, {15'h0, o_monitor_mode});
        rst(MSL_IRQ_SUPPLY, 1'b1, 1'b1);
        chk("mode", 16'h0003, {14'h0, o_monitor_mode, o_blank_entry});
        rst(MSL_IRQ_GROUND, 1'b1, 1'b1);
        chk("mode", 16'h0003, {14'h0, o_monitor_mode, o_blank_entry});
        chk("pll", 16'h014b, {7'h0, o_pll_en, o_pll_mult});
        chk("rst_vec", 16'hfefe, o_reset_vector_addr);
        chk("brk_vec", 16'hfefc, o_break_swi_vector_addr);
        rst(MSL_IRQ_GROUND, 1'b1, 1'b0);
        chk("mode", 16'h0001, {15'h0, o_monitor_mode});
        $display("entry test done");
        repeat (512) @(posedge i_core_clk);
        #1 host.send(10'h000);
        host.recv(fr, ok);
        tmo(ok);
        chk("break", 16'h0000, {6'h00, fr});
        $display("break test done");
        xfer(MSL_CMD_WRITE);
        xfer(a[15:8]);
        xfer(a[7:0]);
        xfer(d);
        wait_hi(o_mem_wr);
        chk("wr_addr", a, o_mem_addr);
        chk("wr_data", {8'h00, d}, {8'h00, o_mem_wdata});
        $display("write test done");
        xfer(MSL_CMD_READ);
        xfer(a[15:8]);
        xfer(a[7:0]);
        host.recv(fr, ok);
        tmo(ok);
        chk("rd_data", {6'h00, 1'b1, d, 1'b0}, {6'h00, fr});
        $display("read test done");
        xfer(MSL_CMD_SPREAD);
        for (int i = 1; i >= 0; i--) begin
            host.recv(fr, ok);
            tmo(ok);
            chk("sp_data", {6'h00, 1'b1, sp[8*i +: 8], 1'b0}, {6'h00, fr});
        end
        $display("stack read test done");
        xfer(MSL_CMD_INDEXED_WRITE_CMD);
        xfer(~d);
        wait_hi(o_mem_wr);
        chk("iwr_addr", 16'(a + 16'h0001), o_mem_addr);
        chk("iwr_data", {8'h00, ~d}, {8'h00, o_mem_wdata});
        $display("indexed write test done");
        xfer(MSL_CMD_RUN);
        wait_hi(o_run);
        chk("run", 16'h0001, {15'h0, o_run});
        $display("run test done");
        give_verdict();
    end
endmodule : tb_top
